// >>> dtf_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dtf_map.vh"
module dtf_top #(
  parameter [10:0] FLOPPY_CYLS = 11'h04d
) (
  input wire CLK_SYS_IN,
  input wire RSTN_IN,
  input wire CE_IN,
  input wire FLOPPY_2SIDE_STRAP_IN,
  input wire [3:0] FIXED_HEADS_STRAP_IN,
  input wire CMD_VALID_IN,
  input wire [7:0] CMD_BYTE_IN,
  input wire OFS_EN_IN,
  input wire [4:0] HEAD_OFS_IN,
  input wire [4:0] CYL_OFS_IN,
  input wire [4:0] INTERLEAVE_IN,
  input wire TRK_READY_IN,
  input wire [7:0] WDATA_IN,
  input wire STAT_ACK_IN,
  output reg CMD_READY_OUT,
  output reg ADDR_VALID_OUT,
  output reg [1:0] DRIVE_SELECT_OUT,
  output reg FLOPPY_SEL_OUT,
  output reg [10:0] CYL_OUT,
  output reg [3:0] HEAD_OUT,
  output reg [5:0] SECTOR_OUT,
  output reg [5:0] SPT_OUT,
  output reg [7:0] TRK_BYTE_OUT,
  output reg TRK_VALID_OUT,
  output reg TRK_MARK_OUT,
  output reg TRK_MFM_OUT,
  output reg WDATA_TAKE_OUT,
  output reg STAT_VALID_OUT,
  output reg [7:0] STAT_BYTE_OUT
);
  localparam [4:0] S_IDLE = 5'h00, S_DEC = 5'h01, S_DIV1 = 5'h02, S_DIV2 = 5'h03;
  localparam [4:0] S_ADDR = 5'h04, S_GAP1 = 5'h05, S_IXM = 5'h06, S_IDM = 5'h07;
  localparam [4:0] S_IDR = 5'h08, S_IDC = 5'h09, S_GAP2 = 5'h0a, S_DTM = 5'h0b;
  localparam [4:0] S_DATA = 5'h0c, S_DTC = 5'h0d, S_GAP3 = 5'h0e, S_GAP4 = 5'h0f;
  localparam [4:0] S_GAP5 = 5'h10, S_STAT0 = 5'h11, S_STAT1 = 5'h12;

  // ==========================================
  // Format lookup: {ok, mfm, size, spt, gap4, gap5}
  function [27:0] dtf_fmt;
    input flop;
    input [2:0] fm;
    input dbl;
    input t0;
    input hd1;
    reg dd;
    reg [1:0] sz;
    begin
      dd = ~fm[2] & ((fm[1:0] != 2'h0) | dbl);
      sz = fm[1:0];
      if (dd && sz == 2'h0) begin
        sz = 2'h1;
      end
      if (t0) begin
        dd = hd1 & dd;
        sz = dd ? 2'h1 : 2'h0;
      end
      if (!flop) begin
        case (fm)
          3'h0: dtf_fmt = {2'h3, 2'h1, 6'h20, 8'h22, 10'h140};
          3'h4: dtf_fmt = {2'h3, 2'h1, 6'h1f, 8'h2c, 10'h150};
          3'h2: dtf_fmt = {2'h3, 2'h2, 6'h11, 8'h39, 10'h154};
          3'h6: dtf_fmt = {2'h3, 2'h2, 6'h10, 8'h5d, 10'h18b};
          default: dtf_fmt = 28'h0;
        endcase
      end else begin
        case ({dd, sz})
          3'h0: dtf_fmt = {2'h2, 2'h0, 6'h1a, 8'h21, 10'h112};
          3'h1: dtf_fmt = {2'h2, 2'h1, 6'h0f, 8'h30, 10'h0d4};
          3'h2: dtf_fmt = {2'h2, 2'h2, 6'h08, 8'h48, 10'h139};
          3'h3: dtf_fmt = {2'h2, 2'h3, 6'h04, 8'h56, 10'h29b};
          3'h5: dtf_fmt = {2'h3, 2'h1, 6'h1a, 8'h42, 10'h28d};
          3'h6: dtf_fmt = {2'h3, 2'h2, 6'h10, 8'h3d, 10'h160};
          3'h7: dtf_fmt = {2'h3, 2'h3, 6'h08, 8'h80, 10'h303};
          default: dtf_fmt = 28'h0;
        endcase
      end
    end
  endfunction

  // ==========================================
  // Check byte update, one byte msb first
  function [15:0] dtf_crc;
    input [15:0] c;
    input [7:0] d;
    integer k;
    reg [15:0] r;
    begin
      r = c;
      for (k = 7; k >= 0; k = k - 1) begin
        r = {r[14:0], 1'b0} ^ ((r[15] ^ d[k]) ? `DTF_CRC_POLY : 16'h0);
      end
      dtf_crc = r;
    end
  endfunction

  // ==========================================
  // Reset release and straps
  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_n = rst_s2_reg;
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  reg strap_done_reg;
  reg dbl_reg;
  reg [3:0] fix_heads_reg;
  always @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      dbl_reg <= 1'b0;
      fix_heads_reg <= 4'h0;
    end else if (CE_IN && !strap_done_reg) begin
      strap_done_reg <= 1'b1;
      dbl_reg <= FLOPPY_2SIDE_STRAP_IN;
      fix_heads_reg <= FIXED_HEADS_STRAP_IN;
    end
  end

  // ==========================================
  // Command decode
  reg [7:0] cmd_mem [0:5];
  reg [2:0] cidx_reg;
  reg [4:0] state_reg;
  reg [10:0] cnt_reg;
  reg [5:0] slot_reg;
  reg [15:0] crc_reg;
  reg [7:0] err_reg;
  reg ovf_reg;
  reg [20:0] rem_reg;
  reg [20:0] quo_reg;
  reg [20:0] dvs_reg;
  reg [4:0] bit_reg;

  wire [1:0] drv = cmd_mem[1][6:5];
  wire flop = drv[1];
  wire physical_address_select = cmd_mem[5][`DTF_B6_PHYS];
  wire del = cmd_mem[5][`DTF_B6_DEL] & flop;
  wire [20:0] lba = {cmd_mem[1][4:0], cmd_mem[2], cmd_mem[3]};
  wire [2:0] fm = cmd_mem[5][2:0];
  wire is_ftrk = cmd_mem[0] == `DTF_OP_FMT_TRACK;
  wire is_wr = (cmd_mem[0] & `DTF_OP_WRITE_MASK) == `DTF_OP_WRITE;
  wire [4:0] heads = flop ? (dbl_reg ? 5'h2 : 5'h1) : ({1'b0, fix_heads_reg} + 5'h1);
  wire [27:0] fgeo = dtf_fmt(flop, fm, dbl_reg, 1'b0, 1'b0);
  wire [27:0] tgeo = dtf_fmt(flop, fm, dbl_reg, CYL_OUT == 11'h0, HEAD_OUT[0]);
  wire [5:0] fspt = fgeo[23:18];
  wire [10:0] spc = {5'h00, fspt} * {6'h00, heads};
  wire mfm = tgeo[26];
  wire [1:0] tsz = tgeo[25:24];
  wire [5:0] tspt = tgeo[23:18];

  // Shift-subtract divider step
  wire [21:0] dsh = {rem_reg, quo_reg[20]};
  wire [21:0] ddf = dsh - {1'b0, dvs_reg};
  wire dge = ~ddf[21];
  wire [20:0] rem_next = dge ? ddf[20:0] : dsh[20:0];
  wire [20:0] quo_next = {quo_reg[19:0], dge};

  wire range_bad = (flop && CYL_OUT >= FLOPPY_CYLS) || ({1'b0, HEAD_OUT} >= heads) || ovf_reg;
  wire sect_bad = !is_ftrk && (SECTOR_OUT == 6'h0 || SECTOR_OUT > fspt);
  wire [7:0] chk = !fgeo[27] ? `DTF_ERR_FORMAT : range_bad ? `DTF_ERR_RANGE :
                   sect_bad ? `DTF_ERR_SECTOR : `DTF_ERR_NONE;

  // ==========================================
  // Sector numbering rotation
  wire [4:0] offs = !OFS_EN_IN ? 5'h0 : (HEAD_OUT == 4'h0 ? CYL_OFS_IN : HEAD_OFS_IN);
  wire [4:0] eff = (offs > INTERLEAVE_IN) ? offs : INTERLEAVE_IN;
  wire [4:0] rot = (eff > 5'h1) ? eff - 5'h1 : 5'h0;
  wire [5:0] rotc = ({1'b0, rot} >= tspt) ? 6'h0 : {1'b0, rot};
  wire [6:0] sid = {1'b0, slot_reg} + ((slot_reg >= rotc) ? 7'h1 : {1'b0, tspt} + 7'h1) - {1'b0, rotc};

  // ==========================================
  // Track byte selection
  reg [7:0] sbyte;
  reg smark;
  reg [10:0] slen;
  reg [4:0] nstate;
  wire [10:0] mlen = mfm ? 11'h4 : 11'h1;
  wire sync = mfm && cnt_reg < 11'h3;
  always @* begin
    sbyte = mfm ? `DTF_FILL_MFM : `DTF_FILL_FM;
    smark = 1'b0;
    slen = 11'h1;
    nstate = state_reg;
    case (state_reg)
      S_GAP1: begin
        slen = mfm ? `DTF_G1_DD : `DTF_G1_SD;
        nstate = S_IXM;
      end
      S_IXM: begin
        slen = mlen;
        smark = 1'b1;
        sbyte = sync ? `DTF_SYNC_IDX : `DTF_IDX_MARK;
        nstate = S_IDM;
      end
      S_IDM: begin
        slen = mlen;
        smark = 1'b1;
        sbyte = sync ? `DTF_SYNC_AM : `DTF_ID_MARK;
        nstate = S_IDR;
      end
      S_IDR: begin
        slen = 11'h4;
        case (cnt_reg[1:0])
          2'h0: sbyte = CYL_OUT[7:0];
          2'h1: sbyte = {4'h0, HEAD_OUT};
          2'h2: sbyte = {2'h0, sid[5:0]};
          default: sbyte = {6'h0, tsz};
        endcase
        nstate = S_IDC;
      end
      S_IDC: begin
        slen = 11'h2;
        sbyte = cnt_reg[0] ? crc_reg[7:0] : crc_reg[15:8];
        nstate = S_GAP2;
      end
      S_GAP2: begin
        slen = mfm ? `DTF_G2_DD : `DTF_G2_SD;
        nstate = S_DTM;
      end
      S_DTM: begin
        slen = mlen;
        smark = 1'b1;
        sbyte = sync ? `DTF_SYNC_AM : (del ? `DTF_DEL_MARK : `DTF_DATA_MARK);
        nstate = S_DATA;
      end
      S_DATA: begin
        slen = 11'h080 << tsz;
        sbyte = is_wr ? WDATA_IN : `DTF_FILL_DATA;
        nstate = S_DTC;
      end
      S_DTC: begin
        slen = 11'h2;
        sbyte = cnt_reg[0] ? crc_reg[7:0] : crc_reg[15:8];
        nstate = is_wr ? S_STAT0 : S_GAP3;
      end
      S_GAP3: begin
        slen = mfm ? `DTF_G3_DD : `DTF_G3_SD;
        nstate = (slot_reg == tspt - 6'h1) ? S_GAP4 : S_IDM;
      end
      S_GAP4: begin
        slen = {3'h0, tgeo[17:10]};
        nstate = S_GAP5;
      end
      S_GAP5: begin
        slen = {1'b0, tgeo[9:0]};
        nstate = S_STAT0;
      end
      default: begin
        nstate = state_reg;
      end
    endcase
  end
  wire crc_start = (state_reg == S_IDM || state_reg == S_DTM) && cnt_reg == 11'h0;
  wire crc_add = state_reg == S_IDR || state_reg == S_DATA || crc_start ||
                 state_reg == S_IDM || state_reg == S_DTM;
  wire streaming = state_reg >= S_GAP1 && state_reg <= S_GAP5;

  // ==========================================
  // Main sequencer
  integer i;
  always @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 6; i = i + 1) begin
        cmd_mem[i] <= 8'h0;
      end
      cidx_reg <= 3'h0;
      state_reg <= S_IDLE;
      cnt_reg <= 11'h0;
      slot_reg <= 6'h0;
      crc_reg <= `DTF_CRC_INIT;
      err_reg <= `DTF_ERR_NONE;
      ovf_reg <= 1'b0;
      rem_reg <= 21'h0;
      quo_reg <= 21'h0;
      dvs_reg <= 21'h0;
      bit_reg <= 5'h0;
      CMD_READY_OUT <= 1'b0;
      ADDR_VALID_OUT <= 1'b0;
      DRIVE_SELECT_OUT <= 2'h0;
      FLOPPY_SEL_OUT <= 1'b0;
      CYL_OUT <= 11'h0;
      HEAD_OUT <= 4'h0;
      SECTOR_OUT <= 6'h0;
      SPT_OUT <= 6'h0;
      TRK_BYTE_OUT <= 8'h0;
      TRK_VALID_OUT <= 1'b0;
      TRK_MARK_OUT <= 1'b0;
      TRK_MFM_OUT <= 1'b0;
      WDATA_TAKE_OUT <= 1'b0;
      STAT_VALID_OUT <= 1'b0;
      STAT_BYTE_OUT <= 8'h0;
    end else if (CE_IN) begin
      ADDR_VALID_OUT <= 1'b0;
      TRK_VALID_OUT <= 1'b0;
      WDATA_TAKE_OUT <= 1'b0;
      if (streaming) begin
        if (TRK_READY_IN) begin
          TRK_BYTE_OUT <= sbyte;
          TRK_VALID_OUT <= 1'b1;
          TRK_MARK_OUT <= smark;
          TRK_MFM_OUT <= mfm;
          WDATA_TAKE_OUT <= state_reg == S_DATA && is_wr;
          if (crc_add) begin
            crc_reg <= dtf_crc(crc_start ? `DTF_CRC_INIT : crc_reg, sbyte);
          end
          if (cnt_reg == slen - 11'h1) begin
            cnt_reg <= 11'h0;
            state_reg <= nstate;
            if (state_reg == S_GAP3) begin
              slot_reg <= slot_reg + 6'h1;
            end
          end else begin
            cnt_reg <= cnt_reg + 11'h1;
          end
        end
      end else begin
        case (state_reg)
          S_IDLE: begin
            CMD_READY_OUT <= strap_done_reg;
            if (CMD_VALID_IN && CMD_READY_OUT) begin
              cmd_mem[cidx_reg] <= CMD_BYTE_IN;
              if (cidx_reg == `DTF_CMD_LEN - 3'h1) begin
                cidx_reg <= 3'h0;
                CMD_READY_OUT <= 1'b0;
                state_reg <= S_DEC;
              end else begin
                cidx_reg <= cidx_reg + 3'h1;
              end
            end
          end
          S_DEC: begin
            ovf_reg <= 1'b0;
            DRIVE_SELECT_OUT <= drv;
            FLOPPY_SEL_OUT <= flop;
            SPT_OUT <= fspt;
            if (!physical_address_select && fgeo[27]) begin
              rem_reg <= 21'h0;
              quo_reg <= lba;
              dvs_reg <= {10'h0, spc};
              bit_reg <= 5'h0;
              state_reg <= S_DIV1;
            end else begin
              CYL_OUT <= {cmd_mem[1][4], cmd_mem[2][7:6], cmd_mem[3]};
              HEAD_OUT <= cmd_mem[1][3:0];
              SECTOR_OUT <= cmd_mem[2][5:0];
              state_reg <= S_ADDR;
            end
          end
          S_DIV1, S_DIV2: begin
            rem_reg <= rem_next;
            quo_reg <= quo_next;
            bit_reg <= bit_reg + 5'h1;
            if (bit_reg == 5'h14) begin
              bit_reg <= 5'h0;
              if (state_reg == S_DIV1) begin
                CYL_OUT <= quo_next[10:0];
                ovf_reg <= |quo_next[20:11];
                rem_reg <= 21'h0;
                quo_reg <= rem_next;
                dvs_reg <= {15'h0, fspt};
                state_reg <= S_DIV2;
              end else begin
                HEAD_OUT <= quo_next[3:0];
                SECTOR_OUT <= rem_next[5:0] + 6'h1;
                state_reg <= S_ADDR;
              end
            end
          end
          S_ADDR: begin
            err_reg <= chk;
            ADDR_VALID_OUT <= 1'b1;
            cnt_reg <= 11'h0;
            slot_reg <= 6'h0;
            if (chk != `DTF_ERR_NONE || !(is_ftrk || is_wr)) begin
              state_reg <= S_STAT0;
            end else begin
              state_reg <= is_ftrk ? S_GAP1 : S_DTM;
            end
          end
          S_STAT0: begin
            STAT_VALID_OUT <= 1'b1;
            STAT_BYTE_OUT <= err_reg;
            if (STAT_VALID_OUT && STAT_ACK_IN) begin
              STAT_BYTE_OUT <= {5'h0, FLOPPY_SEL_OUT, DRIVE_SELECT_OUT};
              state_reg <= S_STAT1;
            end
          end
          S_STAT1: begin
            if (STAT_ACK_IN) begin
              STAT_VALID_OUT <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // dtf_top
`default_nettype wire

// >>> dtf_map.vh
`ifndef DTF_MAP_VH
`define DTF_MAP_VH
`define DTF_CMD_LEN 3'h6
`define DTF_OP_FMT_TRACK 8'h06
`define DTF_OP_WRITE 8'h0a
`define DTF_OP_WRITE_MASK 8'hef
`define DTF_B6_PHYS 3
`define DTF_B6_DEL 5
`define DTF_G1_SD 11'h02e
`define DTF_G2_SD 11'h020
`define DTF_G3_SD 11'h011
`define DTF_G1_DD 11'h05c
`define DTF_G2_DD 11'h03e
`define DTF_G3_DD 11'h022
`define DTF_SYNC_IDX 8'hc2
`define DTF_SYNC_AM 8'ha1
`define DTF_IDX_MARK 8'hfc
`define DTF_ID_MARK 8'hfe
`define DTF_DATA_MARK 8'hfb
`define DTF_DEL_MARK 8'hf8
`define DTF_FILL_FM 8'hff
`define DTF_FILL_MFM 8'h4e
`define DTF_FILL_DATA 8'he5
`define DTF_CRC_INIT 16'hffff
`define DTF_CRC_POLY 16'h1021
`define DTF_ERR_NONE 8'h00
`define DTF_ERR_FORMAT 8'h01
`define DTF_ERR_RANGE 8'h02
`define DTF_ERR_SECTOR 8'h03
`endif

// >>> dtf_unused_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> dtf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dtf_chk (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic CMD_VALID_IN,
  input wire logic CMD_READY_OUT,
  input wire logic STAT_ACK_IN,
  input wire logic STAT_VALID_OUT,
  input wire logic [7:0] STAT_BYTE_OUT,
  input wire logic ADDR_VALID_OUT,
  input wire logic [1:0] DRIVE_SELECT_OUT,
  input wire logic FLOPPY_SEL_OUT,
  input wire logic TRK_VALID_OUT,
  input wire logic TRK_MARK_OUT,
  input wire logic TRK_MFM_OUT,
  input wire logic [7:0] TRK_BYTE_OUT,
  input wire logic WDATA_TAKE_OUT
);
  // ====================
  // Handshake counters
  logic [2:0] nb_reg;
  logic ack_reg;
  wire take = CE_IN && CMD_VALID_IN && CMD_READY_OUT;
  wire sack = CE_IN && STAT_VALID_OUT && STAT_ACK_IN;
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      nb_reg <= 3'h0;
      ack_reg <= 1'b0;
    end else begin
      if (take) nb_reg <= (nb_reg == 3'h5) ? 3'h0 : nb_reg + 3'h1;
      if (sack) ack_reg <= ~ack_reg;
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RSTN_IN);
  sequence s_last_byte;
    take && nb_reg == 3'h5;
  endsequence
  sequence s_ack_first;
    sack && !ack_reg;
  endsequence
  sequence s_ack_last;
    sack && ack_reg;
  endsequence
  cmd_six_bytes_a: assert property (s_last_byte |=> !CMD_READY_OUT)
    else $error("ready after sixth byte");
  cmd_stat_excl_a: assert property (STAT_VALID_OUT |-> !CMD_READY_OUT)
    else $error("ready during status");
  ready_back_a: assert property (s_ack_last |-> ##[1:3] CMD_READY_OUT)
    else $error("ready not back after status");
  stat_second_a: assert property (s_ack_first |=> STAT_VALID_OUT)
    else $error("second status byte missing");
  stat_two_bytes_a: assert property (s_ack_last |=> !STAT_VALID_OUT)
    else $error("status longer than two bytes");
  stat_drive_a: assert property (s_ack_first |=> STAT_BYTE_OUT == {5'h00, FLOPPY_SEL_OUT, DRIVE_SELECT_OUT})
    else $error("second status byte wrong");
  floppy_sel_a: assert property (ADDR_VALID_OUT |-> FLOPPY_SEL_OUT == DRIVE_SELECT_OUT[1])
    else $error("floppy select mismatch");
  fm_mark_a: assert property (TRK_VALID_OUT && TRK_MARK_OUT && !TRK_MFM_OUT |->
    TRK_BYTE_OUT inside {8'hfc, 8'hfe, 8'hfb, 8'hf8})
    else $error("bad single density mark");
  mfm_mark_a: assert property (TRK_VALID_OUT && TRK_MARK_OUT && TRK_MFM_OUT |->
    TRK_BYTE_OUT inside {8'ha1, 8'hc2, 8'hfc, 8'hfe, 8'hfb, 8'hf8})
    else $error("bad double density mark");
  take_data_a: assert property (WDATA_TAKE_OUT |-> TRK_VALID_OUT && !TRK_MARK_OUT)
    else $error("write data taken outside data");
endmodule // dtf_chk
bind dtf_top dtf_chk u_chk (.CLK_SYS_IN, .RSTN_IN, .CE_IN, .CMD_VALID_IN, .CMD_READY_OUT, .STAT_ACK_IN,
  .STAT_VALID_OUT, .STAT_BYTE_OUT, .ADDR_VALID_OUT, .DRIVE_SELECT_OUT, .FLOPPY_SEL_OUT, .TRK_VALID_OUT,
  .TRK_MARK_OUT, .TRK_MFM_OUT, .TRK_BYTE_OUT, .WDATA_TAKE_OUT);
`default_nettype wire

// >>> dtf_sink.sv
`timescale 1ns/1ps
`default_nettype none
module dtf_sink (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic valid_in,
  input wire logic mark_in,
  input wire logic take_in,
  input wire logic [7:0] byte_in,
  output logic ready_out,
  output logic [7:0] wdata_out
);
  // ====================
  // Stalling consumer
  logic [1:0] cyc_reg = 2'h0;
  logic [15:0] n_reg;
  logic [15:0] nt_reg;
  logic [15:0] sum_reg;
  logic [7:0] nid_reg;
  logic [2:0] pos_reg;
  logic [7:0] buf_b [0:127];
  logic buf_m [0:127];
  initial ready_out = 1'b0;
  assign wdata_out = 8'h3c;
  always @(negedge clk_in) begin
    cyc_reg <= cyc_reg + 2'h1;
    ready_out <= (cyc_reg != 2'h3);
  end
  // ====================
  // Track capture
  always @(posedge clk_in) begin
    if (clr_in) begin
      n_reg <= 16'h0000;
      nt_reg <= 16'h0000;
      sum_reg <= 16'h0000;
      nid_reg <= 8'h00;
      pos_reg <= 3'h7;
    end else if (valid_in) begin
      n_reg <= n_reg + 16'h0001;
      nt_reg <= nt_reg + {15'h0000, take_in};
      if (n_reg < 16'h0080) begin
        buf_b[n_reg[6:0]] <= byte_in;
        buf_m[n_reg[6:0]] <= mark_in;
      end
      if (mark_in && byte_in == 8'hfe) pos_reg <= 3'h0;
      else if (pos_reg != 3'h7) pos_reg <= pos_reg + 3'h1;
      if (mark_in && byte_in == 8'hfe) nid_reg <= nid_reg + 8'h01;
      if (!mark_in && pos_reg == 3'h2) sum_reg <= sum_reg + {8'h00, byte_in};
    end
  end
endmodule // dtf_sink
`default_nettype wire

// >>> test_disk_track_format_addressing.sv
`timescale 1ns/1ps
`default_nettype none
module test_disk_track_format_addressing;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic cvalid = 1'b0;
  logic [7:0] cbyte = 8'h00;
  logic ofs_en = 1'b0;
  logic [4:0] hofs = 5'h00;
  logic [4:0] cofs = 5'h00;
  logic [4:0] ilv = 5'h00;
  logic dbl_strap = 1'b1;
  logic sack = 1'b0;
  logic clr = 1'b1;
  logic rdy, cready, avalid, fsel, tvalid, tmark, tmfm, take, svalid;
  logic [7:0] wdata, tbyte, sbyte;
  logic [1:0] dsel;
  logic [10:0] cyl;
  logic [3:0] head;
  logic [5:0] sec, spt;
  integer n_fail = 0;
  integer checks_done = 0;
  always #5 clk = ~clk;
  dtf_top u_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .FLOPPY_2SIDE_STRAP_IN(dbl_strap),
    .FIXED_HEADS_STRAP_IN(4'h3), .CMD_VALID_IN(cvalid), .CMD_BYTE_IN(cbyte), .OFS_EN_IN(ofs_en),
    .HEAD_OFS_IN(hofs), .CYL_OFS_IN(cofs), .INTERLEAVE_IN(ilv), .TRK_READY_IN(rdy), .WDATA_IN(wdata),
    .STAT_ACK_IN(sack), .CMD_READY_OUT(cready), .ADDR_VALID_OUT(avalid), .DRIVE_SELECT_OUT(dsel),
    .FLOPPY_SEL_OUT(fsel), .CYL_OUT(cyl), .HEAD_OUT(head), .SECTOR_OUT(sec), .SPT_OUT(spt),
    .TRK_BYTE_OUT(tbyte), .TRK_VALID_OUT(tvalid), .TRK_MARK_OUT(tmark), .TRK_MFM_OUT(tmfm),
    .WDATA_TAKE_OUT(take), .STAT_VALID_OUT(svalid), .STAT_BYTE_OUT(sbyte));
  dtf_sink u_sink (.clk_in(clk), .clr_in(clr), .valid_in(tvalid), .mark_in(tmark), .take_in(take),
    .byte_in(tbyte), .ready_out(rdy), .wdata_out(wdata));
  // ====================
  // Tasks
  task automatic end_sim;
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo;
    n_fail++;
    $display("ERROR %0t handshake timeout", $time);
    end_sim;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input logic want_addr, input integer lim);
    integer i;
    for (i = 0; i < lim && !(want_addr ? avalid : svalid); i++) @(negedge clk);
    if (i == lim) tmo;
  endtask
  task automatic send(input logic [47:0] c);
    integer k;
    integer i;
    for (k = 5; k >= 0; k--) begin
      cvalid = 1'b1;
      cbyte = c[8 * k +: 8];
      for (i = 0; i < 50 && cready !== 1'b1; i++) @(negedge clk);
      if (i == 50) tmo;
      @(negedge clk);
    end
    cvalid = 1'b0;
  endtask
  task automatic get_stat(output logic [15:0] st);
    wait_for(1'b0, 30000);
    st[15:8] = sbyte;
    sack = 1'b1;
    @(negedge clk);
    wait_for(1'b0, 10);
    st[7:0] = sbyte;
    @(negedge clk);
    sack = 1'b0;
  endtask
  task automatic addr(input logic [1:0] d, input logic phys, input logic [2:0] fm, input logic [20:0] a,
    input logic [10:0] ec, input logic [3:0] eh, input logic [5:0] es, input logic [5:0] en, input logic [7:0] est);
    logic [15:0] st;
    if (phys) send({8'h0b, 1'b0, d, a[20], a[9:6], a[19:18], a[5:0], a[17:10], 8'h01, 4'h0, phys, fm});
    else send({8'h0b, 1'b0, d, a, 8'h01, 4'h0, phys, fm});
    if (est == 8'h00) begin
      wait_for(1'b1, 100);
      chk({5'h00, cyl}, {5'h00, ec});
      chk({head, sec, spt}, {eh, es, en});
    end
    get_stat(st);
    chk(st, {est, 5'h00, d[1], d});
  endtask
  task automatic fmt_trk(input logic [2:0] fm, input logic [10:0] c, input logic [3:0] h, input logic mfm,
    input logic [15:0] en, input logic [7:0] ns, input logic [7:0] sz, input logic [7:0] fs);
    logic [15:0] st;
    integer p;
    integer q;
    integer s;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    send({8'h06, 3'h2, c[10], h, c[9:8], 6'h01, c[7:0], 8'h01, 5'h01, fm});
    get_stat(st);
    p = mfm ? 92 : 46;
    q = mfm ? 100 : 48;
    s = ns * (ns + 1) / 2;
    chk(st, 16'h0006);
    chk(u_sink.n_reg, en);
    chk({6'h00, u_sink.buf_m[p - 1], u_sink.buf_m[p], u_sink.buf_b[p]}, {8'h01, mfm ? 8'hc2 : 8'hfc});
    chk({u_sink.buf_b[q], u_sink.buf_b[q + 1]}, {c[7:0], 4'h0, h});
    chk({u_sink.buf_b[q + 2], u_sink.buf_b[q + 3]}, {fs, sz});
    chk({u_sink.nid_reg, 7'h00, tmfm}, {ns, 7'h00, mfm});
    chk(u_sink.sum_reg, s[15:0]);
  endtask
  task automatic wr(input logic [7:0] op, input logic [2:0] fm, input logic del, input logic mfm,
    input logic [15:0] len);
    logic [15:0] st;
    integer p;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    send({op, 3'h2, 1'b0, 4'h0, 2'h0, 6'h02, 8'h03, 8'h01, 2'h0, del, 2'h1, fm});
    get_stat(st);
    p = mfm ? 3 : 0;
    chk(st, 16'h0006);
    chk(u_sink.n_reg, len + (mfm ? 16'h0006 : 16'h0003));
    chk(u_sink.nt_reg, len);
    chk({7'h00, u_sink.buf_m[p], u_sink.buf_b[p]}, {8'h01, del ? 8'hf8 : 8'hfb});
    chk({7'h00, u_sink.buf_m[p + 1], u_sink.buf_b[p + 1]}, 16'h003c);
  endtask
  // ====================
  // Main sequence
  initial begin
    logic [2:0] f;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    addr(2'h0, 1'b0, 3'h0, 21'h000000, 11'h000, 4'h0, 6'h01, 6'h20, 8'h00);
    dbl_strap = 1'b0;
    addr(2'h0, 1'b0, 3'h0, 21'h0000a1, 11'h001, 4'h1, 6'h02, 6'h20, 8'h00);
    addr(2'h1, 1'b0, 3'h4, 21'h00011c, 11'h002, 4'h1, 6'h06, 6'h1f, 8'h00);
    addr(2'h0, 1'b0, 3'h2, 21'h000011, 11'h000, 4'h1, 6'h01, 6'h11, 8'h00);
    addr(2'h0, 1'b0, 3'h6, 21'h00003f, 11'h000, 4'h3, 6'h10, 6'h10, 8'h00);
    f = 3'h1;
    repeat (4) begin
      addr(2'h0, 1'b0, f, 21'h000000, 11'h000, 4'h0, 6'h00, 6'h00, 8'h01);
      f = f + 3'h2;
    end
    addr(2'h0, 1'b0, 3'h0, 21'h100000, 11'h000, 4'h0, 6'h00, 6'h00, 8'h02);
    addr(2'h2, 1'b0, 3'h4, 21'h00003c, 11'h001, 4'h0, 6'h09, 6'h1a, 8'h00);
    addr(2'h2, 1'b0, 3'h5, 21'h00000f, 11'h000, 4'h1, 6'h01, 6'h0f, 8'h00);
    addr(2'h2, 1'b0, 3'h6, 21'h000008, 11'h000, 4'h1, 6'h01, 6'h08, 8'h00);
    addr(2'h2, 1'b0, 3'h7, 21'h000009, 11'h001, 4'h0, 6'h02, 6'h04, 8'h00);
    addr(2'h3, 1'b0, 3'h1, 21'h00009c, 11'h003, 4'h0, 6'h01, 6'h1a, 8'h00);
    addr(2'h2, 1'b0, 3'h2, 21'h000010, 11'h000, 4'h1, 6'h01, 6'h10, 8'h00);
    addr(2'h2, 1'b0, 3'h3, 21'h000011, 11'h001, 4'h0, 6'h02, 6'h08, 8'h00);
    addr(2'h2, 1'b0, 3'h0, 21'h000034, 11'h001, 4'h0, 6'h01, 6'h1a, 8'h00);
    addr(2'h2, 1'b1, 3'h4, {11'h04c, 4'h1, 6'h1a}, 11'h04c, 4'h1, 6'h1a, 6'h1a, 8'h00);
    addr(2'h2, 1'b1, 3'h4, {11'h04d, 4'h0, 6'h01}, 11'h000, 4'h0, 6'h00, 6'h00, 8'h02);
    addr(2'h2, 1'b1, 3'h4, {11'h003, 4'h0, 6'h00}, 11'h000, 4'h0, 6'h00, 6'h00, 8'h03);
    addr(2'h2, 1'b1, 3'h4, {11'h003, 4'h0, 6'h1b}, 11'h000, 4'h0, 6'h00, 6'h00, 8'h03);
    addr(2'h0, 1'b1, 3'h0, {11'h5e8, 4'h3, 6'h20}, 11'h5e8, 4'h3, 6'h20, 6'h20, 8'h00);
    addr(2'h0, 1'b1, 3'h0, {11'h001, 4'h4, 6'h01}, 11'h000, 4'h0, 6'h00, 6'h00, 8'h02);
    dbl_strap = 1'b1;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    fmt_trk(3'h3, 11'h000, 4'h0, 1'b0, 16'h1460, 8'h1a, 8'h00, 8'h01);
    fmt_trk(3'h2, 11'h005, 4'h0, 1'b1, 16'h28fd, 8'h10, 8'h02, 8'h01);
    fmt_trk(3'h2, 11'h000, 4'h1, 1'b1, 16'h288f, 8'h1a, 8'h01, 8'h01);
    fmt_trk(3'h7, 11'h002, 4'h0, 1'b0, 16'h140c, 8'h04, 8'h03, 8'h01);
    ofs_en = 1'b1;
    hofs = 5'h05;
    cofs = 5'h03;
    ilv = 5'h04;
    fmt_trk(3'h3, 11'h005, 4'h1, 1'b1, 16'h2763, 8'h08, 8'h03, 8'h05);
    fmt_trk(3'h7, 11'h002, 4'h0, 1'b0, 16'h140c, 8'h04, 8'h03, 8'h02);
    ofs_en = 1'b0;
    wr(8'h0a, 3'h4, 1'b0, 1'b0, 16'h0080);
    wr(8'h1a, 3'h1, 1'b1, 1'b1, 16'h0100);
    end_sim;
  end
endmodule // test_disk_track_format_addressing
`default_nettype wire
